// [incl_switch_pkg.sv]
// shared constants, register map and carrier types of the inclination switch
package incl_switch_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ANGLE_W = 16;
  localparam int DAC_W = 12;
  localparam int DIV_W = 28;
  localparam int DEN_W = 17;
  localparam int DIV_STEPS = 28;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int SAMPLE_RATE_HZ = 250;
  // longest sample period, rounded down to whole cycles
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE_HZ;

  // ****************************************
  // angle scale, units of 0.01 degree
  // ****************************************
  localparam logic signed [16:0] FULL_TURN = 17'sh0_8CA0;
  localparam logic signed [16:0] HALF_TURN = 17'sh0_4650;

  // ****************************************
  // output codes
  // ****************************************
  localparam logic [11:0] VOLT_CODE_HIGH = 12'hFFF;
  localparam logic [11:0] VOLT_CODE_LOW = 12'h000;
  localparam logic [11:0] VOLT_CODE_MIN = 12'h19A;
  localparam logic [11:0] VOLT_CODE_SPAN = 12'hCCC;
  localparam logic [11:0] CURR_CODE_MIN = 12'h333;
  localparam logic [11:0] CURR_CODE_SPAN = 12'hCCC;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ON_LEVEL = 8'h04;
  localparam logic [7:0] OFF_OFF_LEVEL = 8'h08;
  localparam logic [7:0] OFF_ON_DELAY = 8'h0C;
  localparam logic [7:0] OFF_OFF_DELAY = 8'h10;
  localparam logic [7:0] OFF_ZERO_REF = 8'h14;
  localparam logic [7:0] OFF_HALF_RANGE = 8'h18;
  localparam logic [7:0] OFF_VALUE = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_SWITCHING = 0;
  localparam int CTRL_DELAYED = 1;
  localparam int CTRL_CURRENT = 2;
  localparam int IRQ_SAMPLE = 0;
  localparam int IRQ_SW_ON = 1;
  localparam int IRQ_SW_OFF = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam logic [15:0] ON_LEVEL_RESET = 16'h03E8;
  localparam logic [15:0] OFF_LEVEL_RESET = 16'h01F4;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam logic [15:0] ZERO_REF_RESET = 16'h0000;
  localparam logic [15:0] HALF_RANGE_RESET = 16'h4650;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic valid;
    logic signed [15:0] angle;
  } sample_t;

  typedef struct packed {
    logic volt_en;
    logic [11:0] volt_code;
    logic curr_en;
    logic [11:0] curr_code;
  } analog_t;

endpackage

// [span_divider.sv]
// iterative restoring divider used to scale angles onto the output span
`timescale 1ns/1ns
module span_divider
  import incl_switch_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic start,
  input wire logic [27:0] dividend,
  input wire logic [16:0] divisor,
  output logic done,
  output logic [27:0] quotient
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [4:0] steps;
    logic [16:0] rem;
    logic [27:0] quo;
    logic [16:0] den;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;
  logic [17:0] trial;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    trial = {st.rem, st.quo[27]};
    if (start) begin
      // a new start drops any run in flight
      next_st.busy = 1'b1;
      next_st.steps = 5'(DIV_STEPS);
      next_st.rem = '0;
      next_st.quo = dividend;
      next_st.den = divisor;
    end else if (st.busy) begin
      if (trial >= {1'b0, st.den}) begin
        next_st.rem = 17'(trial - {1'b0, st.den});
        next_st.quo = {st.quo[26:0], 1'b1};
      end else begin
        next_st.rem = trial[16:0];
        next_st.quo = {st.quo[26:0], 1'b0};
      end
      next_st.steps = st.steps - 5'd1;
      if (st.steps == 5'd1) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;
  assign quotient = st.quo;

endmodule

// [incl_switch.sv]
// inclination threshold switch with hysteresis, debounce and range scaling
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ns

module incl_switch
  import incl_switch_pkg::*;
#(
  parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  input wire sample_t sample_in,
  output logic sample_req,
  output logic switch_out,
  output analog_t analog_out,
  output logic irq
);

  typedef struct packed {
    logic [2:0] ctrl;
    logic signed [15:0] on_level;
    logic signed [15:0] off_level;
    logic [15:0] on_delay;
    logic [15:0] off_delay;
    logic signed [15:0] zero_ref;
    logic [15:0] half_range;
    logic signed [15:0] rel;
    logic [15:0] value;
    logic sw;
    logic trig;
    logic [15:0] dly_cnt;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic irq;
    logic [31:0] tick_cnt;
    logic sample_req;
    logic div_start;
    logic [27:0] div_num;
    logic [16:0] div_den;
    analog_t ana;
    apb_rsp_t rsp;
  } state_t;

  state_t st;
  state_t next_st;
  logic div_done;
  logic [27:0] div_quo;

  // ****************************************
  // scaling divider
  // ****************************************
  span_divider u_div (
    .clock(clock),
    .nrst(nrst),
    .start(st.div_start),
    .dividend(st.div_num),
    .divisor(st.div_den),
    .done(div_done),
    .quotient(div_quo)
  );

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    logic signed [16:0] diff;
    logic signed [16:0] rel;
    logic signed [16:0] hr;
    logic signed [16:0] clamped;
    logic [16:0] cnt_inc;
    logic [2:0] events;
    logic [2:0] w1c;
    logic [11:0] span;
    logic trig_on;
    logic trig_off;
    logic setup;
    logic wr;
    diff = '0;
    rel = '0;
    hr = '0;
    clamped = '0;
    cnt_inc = '0;
    events = '0;
    w1c = '0;
    span = '0;
    trig_on = 1'b0;
    trig_off = 1'b0;
    setup = apb_req.psel && !apb_req.penable;
    wr = apb_req.psel && apb_req.penable && st.rsp.pready && apb_req.pwrite && !st.rsp.pslverr;

    next_st = st;
    next_st.sample_req = 1'b0;
    next_st.div_start = 1'b0;
    next_st.rsp.pready = 1'b0;
    next_st.rsp.pslverr = 1'b0;

    // ****************************************
    // sample request timer
    // ****************************************
    // free-running sample request
    if (st.tick_cnt >= 32'(SAMPLE_PERIOD - 1)) begin
      next_st.tick_cnt = '0;
      next_st.sample_req = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 32'd1;
    end

    // ****************************************
    // register read
    // ****************************************
    // answer in the access phase
    if (setup) begin
      next_st.rsp.pready = 1'b1;
      next_st.rsp.prdata = '0;
      unique case (apb_req.paddr)
        OFF_CTRL: next_st.rsp.prdata = {29'h0, st.ctrl};
        OFF_ON_LEVEL: next_st.rsp.prdata = {{16{st.on_level[15]}}, st.on_level};
        OFF_OFF_LEVEL: next_st.rsp.prdata = {{16{st.off_level[15]}}, st.off_level};
        OFF_ON_DELAY: next_st.rsp.prdata = {16'h0, st.on_delay};
        OFF_OFF_DELAY: next_st.rsp.prdata = {16'h0, st.off_delay};
        OFF_ZERO_REF: next_st.rsp.prdata = {{16{st.zero_ref[15]}}, st.zero_ref};
        OFF_HALF_RANGE: next_st.rsp.prdata = {16'h0, st.half_range};
        OFF_VALUE: next_st.rsp.prdata = {{16{st.value[15]}}, st.value};
        OFF_STATUS: next_st.rsp.prdata = {30'h0, st.trig, st.sw};
        OFF_IRQ_STATUS: next_st.rsp.prdata = {29'h0, st.irq_st};
        OFF_IRQ_MASK: next_st.rsp.prdata = {29'h0, st.irq_mask};
        default: next_st.rsp.pslverr = 1'b1;
      endcase
    end

    // ****************************************
    // register write
    // ****************************************
    if (wr) begin
      unique case (apb_req.paddr)
        OFF_CTRL: next_st.ctrl = apb_req.pwdata[2:0];
        OFF_ON_LEVEL: next_st.on_level = apb_req.pwdata[15:0];
        OFF_OFF_LEVEL: next_st.off_level = apb_req.pwdata[15:0];
        OFF_ON_DELAY: next_st.on_delay = apb_req.pwdata[15:0];
        OFF_OFF_DELAY: next_st.off_delay = apb_req.pwdata[15:0];
        OFF_ZERO_REF: next_st.zero_ref = apb_req.pwdata[15:0];
        OFF_HALF_RANGE: begin
          // zero would divide by zero, beyond half a turn is meaningless
          if (apb_req.pwdata[15:0] == 16'h0000) begin
            next_st.half_range = 16'h0001;
          end else if (apb_req.pwdata[15:0] > HALF_TURN[15:0]) begin
            next_st.half_range = HALF_TURN[15:0];
          end else begin
            next_st.half_range = apb_req.pwdata[15:0];
          end
        end
        OFF_IRQ_STATUS: w1c = apb_req.pwdata[2:0];
        OFF_IRQ_MASK: next_st.irq_mask = apb_req.pwdata[2:0];
        default: ;
      endcase
    end

    // ****************************************
    // per-sample evaluation
    // ****************************************
    if (sample_in.valid) begin
      // subtract zero reference, wrap to half a turn
      diff = 17'(sample_in.angle) - 17'(st.zero_ref);
      if (diff > HALF_TURN) begin
        rel = diff - FULL_TURN;
      end else if (diff < -HALF_TURN) begin
        rel = diff + FULL_TURN;
      end else begin
        rel = diff;
      end
      next_st.rel = rel[15:0];
      events[IRQ_SAMPLE] = 1'b1;
      trig_on = rel >= 17'(st.on_level);
      trig_off = rel < 17'(st.off_level);
      cnt_inc = {1'b0, st.dly_cnt} + 17'd1;

      // ****************************************
      // switching mode
      // ****************************************
      if (st.ctrl[CTRL_SWITCHING]) begin
        next_st.trig = st.sw ? !trig_off : trig_on;
        if (!st.sw) begin
          if (trig_on) begin
            if (!st.ctrl[CTRL_DELAYED] || cnt_inc >= {1'b0, st.on_delay}) begin
              next_st.sw = 1'b1;
              next_st.dly_cnt = '0;
              events[IRQ_SW_ON] = 1'b1;
            end else begin
              next_st.dly_cnt = cnt_inc[15:0];
            end
          end else begin
            next_st.dly_cnt = '0;
          end
        end else begin
          if (trig_off) begin
            if (!st.ctrl[CTRL_DELAYED] || cnt_inc >= {1'b0, st.off_delay}) begin
              next_st.sw = 1'b0;
              next_st.dly_cnt = '0;
              events[IRQ_SW_OFF] = 1'b1;
            end else begin
              next_st.dly_cnt = cnt_inc[15:0];
            end
          end else begin
            next_st.dly_cnt = '0;
          end
        end
        next_st.value = next_st.sw ? st.on_level : 16'h0000;
        // switching drives the voltage pin only
        next_st.ana.volt_en = 1'b1;
        next_st.ana.volt_code = next_st.sw ? VOLT_CODE_HIGH : VOLT_CODE_LOW;
        next_st.ana.curr_en = 1'b0;
        next_st.ana.curr_code = '0;
      end else begin
        // ****************************************
        // continuous mode
        // ****************************************
        // leaving switching mode drops a held 5 V level at the first sample in continuous mode
        if (st.sw) begin
          next_st.ana.volt_code = VOLT_CODE_LOW;
        end
        next_st.sw = 1'b0;
        next_st.trig = 1'b0;
        next_st.dly_cnt = '0;
        next_st.value = rel[15:0];
        // clamp to the range, then scale on the divider
        hr = 17'(st.half_range);
        if (rel > hr) begin
          clamped = hr;
        end else if (rel < -hr) begin
          clamped = -hr;
        end else begin
          clamped = rel;
        end
        span = st.ctrl[CTRL_CURRENT] ? CURR_CODE_SPAN : VOLT_CODE_SPAN;
        next_st.div_num = 28'(17'(clamped + hr)) * 28'(span);
        next_st.div_den = 17'(hr <<< 1);
        next_st.div_start = 1'b1;
      end
    end

    // ****************************************
    // analog output
    // ****************************************
    // scaled code goes to the selected pin only
    if (div_done && !st.ctrl[CTRL_SWITCHING]) begin
      next_st.ana.curr_en = st.ctrl[CTRL_CURRENT];
      next_st.ana.volt_en = !st.ctrl[CTRL_CURRENT];
      next_st.ana.curr_code = st.ctrl[CTRL_CURRENT] ? 12'(CURR_CODE_MIN + div_quo[11:0]) : '0;
      next_st.ana.volt_code = st.ctrl[CTRL_CURRENT] ? '0 : 12'(VOLT_CODE_MIN + div_quo[11:0]);
    end

    // ****************************************
    // interrupts
    // ****************************************
    // set wins over a clear in the same cycle
    next_st.irq_st = (st.irq_st & ~w1c) | events;
    next_st.irq = |(next_st.irq_st & next_st.irq_mask);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
      st.on_level <= ON_LEVEL_RESET;
      st.off_level <= OFF_LEVEL_RESET;
      st.on_delay <= DELAY_RESET;
      st.off_delay <= DELAY_RESET;
      st.zero_ref <= ZERO_REF_RESET;
      st.half_range <= HALF_RANGE_RESET;
      st.irq_mask <= IRQ_MASK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign apb_rsp = st.rsp;
  assign sample_req = st.sample_req;
  assign switch_out = st.sw;
  assign analog_out = st.ana;
  assign irq = st.irq;

endmodule

// [incl_switch_checker.sv]
// port-level assertions for the inclination switch
`timescale 1ns/1ns
module incl_switch_checker
  import incl_switch_pkg::*;
#(
  parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire apb_req_t apb_req,
  input wire apb_rsp_t apb_rsp,
  input wire sample_t sample_in,
  input wire logic sample_req,
  input wire logic switch_out,
  input wire analog_t analog_out,
  input wire logic irq
);
  logic [31:0] req_gap;
  logic [7:0] since;
  // cycles since last sample, saturating
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      req_gap <= '0;
      since <= 8'hFF;
    end else begin
      req_gap <= sample_req ? 32'd1 : req_gap + 32'd1;
      since <= sample_in.valid ? 8'h00 : (since == 8'hFF ? since : since + 8'h01);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_ready; apb_req.psel && !apb_req.penable |=> apb_rsp.pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_ready_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_err; apb_rsp.pslverr |-> apb_rsp.pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_req_period; sample_req |-> req_gap == SAMPLE_PERIOD; endproperty
  a_req_period: assert property (p_req_period) else $error("sample request period");
  property p_sw_sample; $changed(switch_out) |-> since <= 8'h01; endproperty
  a_sw_sample: assert property (p_sw_sample) else $error("switch moved off sample");
  property p_sw_on;
    $rose(switch_out) |-> analog_out.volt_en && analog_out.volt_code == VOLT_CODE_HIGH;
  endproperty
  a_sw_on: assert property (p_sw_on) else $error("on without high code");
  property p_sw_off; $fell(switch_out) |-> analog_out.volt_code == VOLT_CODE_LOW; endproperty
  a_sw_off: assert property (p_sw_off) else $error("off without low code");
  property p_lat;
    analog_out.curr_en && $changed(analog_out.curr_code) |-> since == 8'd30 || since == 8'd31;
  endproperty
  a_lat: assert property (p_lat) else $error("scaled code latency");
  property p_pins; !(analog_out.volt_en && analog_out.curr_en); endproperty
  a_pins: assert property (p_pins) else $error("both outputs active");
  c_on: cover property ($rose(switch_out));
  c_off: cover property ($fell(switch_out));
  c_err: cover property (apb_rsp.pslverr);
  c_irq: cover property ($rose(irq));
endmodule
bind incl_switch incl_switch_checker #(.SAMPLE_PERIOD(SAMPLE_PERIOD)) u_chk (.clock(clock),
  .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp), .sample_in(sample_in),
  .sample_req(sample_req), .switch_out(switch_out), .analog_out(analog_out), .irq(irq));

// [angle_source.sv]
// front-end model answering sample requests with an angle after a lag
`timescale 1ns/1ns
module angle_source
  import incl_switch_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic sample_req,
  input wire logic signed [15:0] angle,
  input wire logic [3:0] lag,
  output sample_t sample_in
);
  logic [4:0] wait_cnt;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wait_cnt <= '0;
      sample_in <= '0;
    end else begin
      sample_in.valid <= 1'b0;
      // idle bus shows no stale angle
      sample_in.angle <= ~angle;
      if (sample_req) begin
        wait_cnt <= {1'b0, lag} + 5'd1;
      end else if (wait_cnt != 5'd0) begin
        wait_cnt <= wait_cnt - 5'd1;
      end
      if (!sample_req && wait_cnt == 5'd1) begin
        sample_in.valid <= 1'b1;
        sample_in.angle <= angle;
      end
    end
  end
endmodule

// [tb_top.sv]
// self-checking testbench of the inclination switch
`timescale 1ns/1ns
module tb_top
  import incl_switch_pkg::*;
;
  logic clock;
  logic nrst;
  apb_req_t req;
  apb_rsp_t rsp;
  sample_t smp;
  logic sreq;
  logic sw;
  analog_t ana;
  logic irq;
  logic signed [15:0] ang;
  logic [3:0] lag;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  incl_switch #(.SAMPLE_PERIOD(60)) DUT (.clock(clock), .nrst(nrst), .apb_req(req),
    .apb_rsp(rsp), .sample_in(smp), .sample_req(sreq), .switch_out(sw), .analog_out(ana),
    .irq(irq));
  angle_source src (.clock(clock), .nrst(nrst), .sample_req(sreq), .angle(ang), .lag(lag),
    .sample_in(smp));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, well above the expected run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clock);
    req.penable <= 1'b1;
    do @(posedge clock); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0000_0000, r, e);
    chk(nm, exp, r);
  endtask
  task automatic samples(input int n);
    repeat (n) begin
      @(posedge clock);
      // a sample already in flight still runs on the lag latched at its request
      while (sreq !== 1'b1) @(posedge clock);
      while (smp.valid !== 1'b1) @(posedge clock);
    end
    repeat (2) @(posedge clock);
  endtask
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rd_chk("ctrl", OFF_CTRL, {29'h0, CTRL_RESET});
    rd_chk("on_level", OFF_ON_LEVEL, {16'h0, ON_LEVEL_RESET});
    rd_chk("half_range", OFF_HALF_RANGE, {16'h0, HALF_RANGE_RESET});
    xfer(1'b0, 8'h2C, 32'h0000_0000, r, e);
    chk("unmapped_err", 32'h0000_0001, {31'h0, e});
    $display("test reset done");
  endtask
  task automatic t_immediate;
    wr(OFF_CTRL, 32'h0000_0001);
    ang <= 16'sd1200;
    samples(1);
    chk("sw_on", 32'h0000_0001, {31'h0, sw});
    chk("volt_hi", {20'h0, VOLT_CODE_HIGH}, {20'h0, ana.volt_code});
    rd_chk("value_on", OFF_VALUE, 32'h0000_03E8);
    ang <= 16'sd700;
    samples(1);
    chk("sw_hyst", 32'h0000_0001, {31'h0, sw});
    ang <= 16'sd400;
    samples(1);
    chk("volt_lo", {20'h0, VOLT_CODE_LOW}, {20'h0, ana.volt_code});
    rd_chk("value_off", OFF_VALUE, 32'h0000_0000);
    $display("test immediate done");
  endtask
  task automatic t_delay;
    lag <= 4'd6;
    wr(OFF_ON_DELAY, 32'h0000_0003);
    wr(OFF_OFF_DELAY, 32'h0000_0002);
    wr(OFF_CTRL, 32'h0000_0003);
    ang <= 16'sd1200;
    samples(2);
    rd_chk("status_trig", OFF_STATUS, 32'h0000_0002);
    ang <= 16'sd0;
    samples(1);
    ang <= 16'sd1200;
    samples(2);
    chk("sw_restart", 32'h0000_0000, {31'h0, sw});
    samples(1);
    chk("sw_rise", 32'h0000_0001, {31'h0, sw});
    ang <= 16'sd0;
    samples(1);
    chk("sw_hold", 32'h0000_0001, {31'h0, sw});
    samples(1);
    chk("sw_fall", 32'h0000_0000, {31'h0, sw});
    lag <= 4'd0;
    $display("test delay done");
  endtask
  task automatic t_irq;
    rd_chk("irq_events", OFF_IRQ_STATUS, 32'h0000_0007);
    wr(OFF_IRQ_STATUS, 32'h0000_0007);
    wr(OFF_IRQ_MASK, 32'h0000_0001);
    chk("irq_quiet", 32'h0000_0000, {31'h0, irq});
    samples(1);
    chk("irq_set", 32'h0000_0001, {31'h0, irq});
    wr(OFF_IRQ_STATUS, 32'h0000_0007);
    rd_chk("irq_clr", OFF_IRQ_STATUS, 32'h0000_0000);
    chk("irq_low", 32'h0000_0000, {31'h0, irq});
    wr(OFF_IRQ_MASK, 32'h0000_0000);
    samples(1);
    chk("irq_mask", 32'h0000_0000, {31'h0, irq});
    rd_chk("irq_sticky", OFF_IRQ_STATUS, 32'h0000_0001);
    $display("test irq done");
  endtask
  task automatic t_cont;
    wr(OFF_CTRL, 32'h0000_0004);
    wr(OFF_HALF_RANGE, 32'h0000_03E8);
    wr(OFF_ZERO_REF, 32'h0000_01F4);
    ang <= 16'sd1500;
    samples(1);
    repeat (32) @(posedge clock);
    chk("curr_top", 32'h0000_0FFF, {20'h0, ana.curr_code});
    rd_chk("value_rel", OFF_VALUE, 32'h0000_03E8);
    ang <= 16'sd300;
    samples(1);
    repeat (32) @(posedge clock);
    chk("curr_mid", 32'h0000_0851, {20'h0, ana.curr_code});
    rd_chk("value_neg", OFF_VALUE, 32'hFFFF_FF38);
    wr(OFF_CTRL, 32'h0000_0000);
    samples(1);
    repeat (32) @(posedge clock);
    chk("volt_mid", 32'h0000_06B8, {20'h0, ana.volt_code});
    chk("pins", 32'h0000_0002, {30'h0, ana.volt_en, ana.curr_en});
    $display("test continuous done");
  endtask
  initial begin
    nrst = 1'b0;
    req = '0;
    ang = 16'sd0;
    lag = 4'd0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_reset();
    t_immediate();
    t_delay();
    t_irq();
    t_cont();
    summarize();
  end
endmodule
